// file: src/gpx_ports.sv
// Three-port general-purpose I/O with peripheral overrides and parallel slave mode
// Summary of operation
// - Shared-port direction bit 1 tri-states the pin, 0 drives the output latch.
// - An enabled peripheral forces its pin to output or input regardless of direction.
// - Per-pin select chooses port latch or peripheral output as the driven value.
// - Peripheral output enable acts only while that pin's peripheral select is active.
// - Bits 0,1 serve timer oscillator/clock; bit 1 capture two, bit 2 capture one.
// - Bit 3 serial clock, bit 4 serial data in or line, bit 5 serial out.
// - Bit 6 USART transmit or clock, bit 7 USART receive or data.
// - In I2C mode serial clock and data input levels follow the level select bit.
// - Each second-port pin has its own direction bit.
// - Slave mode bit set makes the second port an 8-bit microprocessor data port.
// - Third port has three pins set by control register bits 2 to 0.
// - In slave mode the third-port pins are read, write and chip-select strobes, inputs only where their direction bits are 1.
// - A third-port pin selected as analog reads back as 0.
// - Third-port direction bits drive the pins even in analog use; software keeps inputs.
// - After reset the third-port pins are analog inputs and read 0.
// - Data latches keep value across reset; direction registers reset to all ones.
// - Slave mode bit set selects slave mode; cleared leaves a general-purpose port.
`timescale 1ns/1ps
module gpx_ports
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [gpx_pkg::ADDR_W-1:0] ADDR,
    input wire logic [gpx_pkg::DATA_W-1:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [gpx_pkg::DATA_W-1:0] RDATA,
    input wire logic [gpx_pkg::DATA_W-1:0] SHC_IN,
    output logic [gpx_pkg::DATA_W-1:0] SHC_OUT,
    output logic [gpx_pkg::DATA_W-1:0] SHC_OE,
    input wire logic [gpx_pkg::DATA_W-1:0] PERIPH_SEL,
    input wire logic [gpx_pkg::DATA_W-1:0] PERIPH_OE,
    input wire logic [gpx_pkg::DATA_W-1:0] PERIPH_OUT,
    input wire logic SERIAL_I2C_EN,
    input wire logic SERIAL_LEVEL_SEL,
    output logic [1:0] SERIAL_PIN_LEVEL,
    output logic TMR_CLK_IN,
    output logic TMR_OSC_IN,
    output logic CAPTURE_ONE_IN,
    output logic CAPTURE_TWO_IN,
    output logic SERIAL_CLK_IN,
    output logic SERIAL_DATA_IN,
    output logic USART_CLK_IN,
    output logic USART_DATA_IN,
    input wire logic [gpx_pkg::DATA_W-1:0] SCD_IN,
    output logic [gpx_pkg::DATA_W-1:0] SCD_OUT,
    output logic [gpx_pkg::DATA_W-1:0] SCD_OE,
    input wire logic [gpx_pkg::THIRD_W-1:0] THD_IN,
    output logic [gpx_pkg::THIRD_W-1:0] THD_OUT,
    output logic [gpx_pkg::THIRD_W-1:0] THD_OE,
    output logic SLAVE_MODE
);
    import gpx_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Driven pins read back the driven level, others the pin level
    function automatic logic [DATA_W-1:0] pin_read(
        input logic [DATA_W-1:0] pin_in,
        input logic [DATA_W-1:0] pin_out,
        input logic [DATA_W-1:0] pin_oe
    );
        pin_read = (pin_oe & pin_out) | (~pin_oe & pin_in);
    endfunction : pin_read

    function automatic logic hit_wr(input logic [ADDR_W-1:0] ofs);
        hit_wr = WR_STB && (ADDR == ofs);
    endfunction : hit_wr

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] lat_c_q;
    logic [DATA_W-1:0] lat_d_q;
    logic [THIRD_W-1:0] lat_e_q;
    logic [DATA_W-1:0] tris_c_q;
    logic [DATA_W-1:0] tris_d_q;
    logic [THIRD_W-1:0] tris_e_q;
    logic psp_q;
    logic [THIRD_W-1:0] analog_q;
    logic [DATA_W-1:0] psp_in_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] dir_c_eff;
    logic psp_rd;
    logic psp_wr;

    // Data latches have no reset so they keep their value across it
    always_ff @(posedge CORE_CLK)
    begin
        if (hit_wr(OFS_SHARED_DATA))
        begin
            lat_c_q <= WDATA;
        end
        if (hit_wr(OFS_SECOND_DATA))
        begin
            lat_d_q <= WDATA;
        end
        if (hit_wr(OFS_THIRD_DATA))
        begin
            lat_e_q <= WDATA[THIRD_W-1:0];
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            tris_c_q <= RST_DIR;
            tris_d_q <= RST_DIR;
            tris_e_q <= RST_THIRD_DIR;
            psp_q <= 1'b0;
        end
        else
        begin
            if (hit_wr(OFS_SHARED_DIR))
            begin
                tris_c_q <= WDATA;
            end
            if (hit_wr(OFS_SECOND_DIR))
            begin
                tris_d_q <= WDATA;
            end
            if (hit_wr(OFS_THIRD_DIR_CTRL))
            begin
                tris_e_q <= WDATA[THIRD_W-1:0];
                psp_q <= WDATA[SLAVE_MODE_BIT];
            end
        end
    end

    // Pins come up analog so reads give 0 until software frees them
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            analog_q <= RST_ANALOG;
        end
        else if (hit_wr(OFS_ANALOG_SEL))
        begin
            analog_q <= WDATA[THIRD_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Shared port with peripheral override
    // ------------------------------------------------------------
    always_comb
    begin
        SHC_OUT = (PERIPH_SEL & PERIPH_OUT) | (~PERIPH_SEL & lat_c_q);
        SHC_OE = (PERIPH_SEL & PERIPH_OE) | (~PERIPH_SEL & ~tris_c_q);
    end

    // Direction reads show the override in force, which is why bit edits
    // of this register while a peripheral owns a pin can corrupt it
    assign dir_c_eff = (PERIPH_SEL & ~PERIPH_OE) | (~PERIPH_SEL & tris_c_q);

    assign SERIAL_PIN_LEVEL = SERIAL_I2C_EN ? {2{SERIAL_LEVEL_SEL}} : 2'b00;

    // Pin taps toward the peripherals
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            TMR_CLK_IN <= 1'b0;
            TMR_OSC_IN <= 1'b0;
            CAPTURE_ONE_IN <= 1'b0;
            CAPTURE_TWO_IN <= 1'b0;
            SERIAL_CLK_IN <= 1'b0;
            SERIAL_DATA_IN <= 1'b0;
            USART_CLK_IN <= 1'b0;
            USART_DATA_IN <= 1'b0;
        end
        else
        begin
            TMR_CLK_IN <= SHC_IN[PIN_TMR_OSC_OUT];
            TMR_OSC_IN <= SHC_IN[PIN_TMR_OSC_IN];
            CAPTURE_TWO_IN <= SHC_IN[PIN_CAPTURE_TWO];
            CAPTURE_ONE_IN <= SHC_IN[PIN_CAPTURE_ONE];
            SERIAL_CLK_IN <= SHC_IN[PIN_SERIAL_CLK];
            SERIAL_DATA_IN <= SHC_IN[PIN_SERIAL_DATA];
            USART_CLK_IN <= SHC_IN[PIN_USART_TX];
            USART_DATA_IN <= SHC_IN[PIN_USART_RX];
        end
    end

    // ------------------------------------------------------------
    // Second port and parallel slave mode
    // ------------------------------------------------------------
    // Control strobes are active low and decoded from the raw pins, analog or not;
    // software must have made these pins inputs, otherwise the decode sees its own drive
    assign psp_rd = psp_q && !THD_IN[STRB_READ_BIT] && !THD_IN[STRB_SELECT_BIT];
    assign psp_wr = psp_q && !THD_IN[STRB_WRITE_BIT] && !THD_IN[STRB_SELECT_BIT];

    // Last sampled bus value while write is asserted is the one kept
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            psp_in_q <= ZERO_BYTE;
        end
        else if (psp_wr)
        begin
            psp_in_q <= SCD_IN;
        end
    end

    always_comb
    begin
        SCD_OUT = lat_d_q;
        if (psp_q)
        begin
            SCD_OE = psp_rd ? {DATA_W{1'b1}} : ZERO_BYTE;
        end
        else
        begin
            SCD_OE = ~tris_d_q;
        end
    end

    assign SLAVE_MODE = psp_q;

    // ------------------------------------------------------------
    // Third port
    // ------------------------------------------------------------
    assign THD_OUT = lat_e_q;
    assign THD_OE = ~tris_e_q;

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_d = ZERO_BYTE;
        unique case (ADDR)
            OFS_SHARED_DATA: rdata_d = pin_read(SHC_IN, SHC_OUT, SHC_OE);
            OFS_SECOND_DATA: rdata_d = psp_q ? psp_in_q : pin_read(SCD_IN, SCD_OUT, SCD_OE);
            OFS_THIRD_DATA: rdata_d = {{(DATA_W-THIRD_W){1'b0}}, THD_IN & ~analog_q};
            OFS_SHARED_DIR: rdata_d = dir_c_eff;
            OFS_SECOND_DIR: rdata_d = tris_d_q;
            OFS_THIRD_DIR_CTRL: rdata_d = {3'h0, psp_q, 1'b0, tris_e_q};
            OFS_ANALOG_SEL: rdata_d = {{(DATA_W-THIRD_W){1'b0}}, analog_q};
            default: rdata_d = ZERO_BYTE;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            RDATA <= ZERO_BYTE;
        end
        else if (RD_STB)
        begin
            RDATA <= rdata_d;
        end
        else
        begin
            RDATA <= ZERO_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    a_shared_dir_drive: assert property ((SHC_OE & ~PERIPH_SEL) == (~tris_c_q & ~PERIPH_SEL))
        else $error("shared pin driver disagrees with direction bit");
    a_periph_force: assert property ((SHC_OE & PERIPH_SEL) == (PERIPH_OE & PERIPH_SEL))
        else $error("peripheral did not force pin direction");
    a_pin_select: assert property (((SHC_OUT ^ PERIPH_OUT) & PERIPH_SEL) == ZERO_BYTE)
        else $error("selected pin does not carry peripheral output");
    a_second_dir: assert property (hit_wr(OFS_SECOND_DIR) && !psp_q ##1 !psp_q
        |-> SCD_OE == ~$past(WDATA))
        else $error("second port direction not applied");
    a_slave_enter: assert property (hit_wr(OFS_THIRD_DIR_CTRL) |=> psp_q == $past(WDATA[SLAVE_MODE_BIT]))
        else $error("slave mode bit not taken");
    a_slave_bus: assert property (psp_wr |=> psp_in_q == $past(SCD_IN))
        else $error("slave write did not capture bus");
    a_slave_drive: assert property (psp_q && !psp_rd |-> SCD_OE == ZERO_BYTE)
        else $error("second port driven without slave read");
    a_analog_zero: assert property (RD_STB && ADDR == OFS_THIRD_DATA
        |=> (RDATA[THIRD_W-1:0] & $past(analog_q)) == 3'h0)
        else $error("analog pin read as nonzero");
    a_third_dir: assert property (THD_OE == ~tris_e_q)
        else $error("third port driver ignores direction");
    a_reset_dirs: assert property ($past(RST) |-> tris_c_q == RST_DIR && tris_d_q == RST_DIR
        && analog_q == RST_ANALOG)
        else $error("reset values wrong");
    a_level_sel: assert property (SERIAL_I2C_EN |-> SERIAL_PIN_LEVEL == {2{SERIAL_LEVEL_SEL}})
        else $error("serial pin level select wrong");
    a_read_idle: assert property (!RD_STB |=> RDATA == ZERO_BYTE)
        else $error("read data outside the answer cycle");

    // ------------------------------------------------------------
    // Shared port and pin tap checks
    // ------------------------------------------------------------
    // A peripheral enable on a pin it does not own must never reach the driver
    a_periph_oe_gate: assert property (((SHC_OE ^ ~tris_c_q) & ~PERIPH_SEL & PERIPH_OE) == ZERO_BYTE)
        else $error("peripheral enable leaked to unselected pin");
    a_shared_dir_wr: assert property (hit_wr(OFS_SHARED_DIR) |=> tris_c_q == $past(WDATA))
        else $error("shared direction write not taken");
    a_tap_timer: assert property (1'b1 |=> TMR_CLK_IN == $past(SHC_IN[PIN_TMR_OSC_OUT])
        && TMR_OSC_IN == $past(SHC_IN[PIN_TMR_OSC_IN])
        && CAPTURE_TWO_IN == $past(SHC_IN[PIN_CAPTURE_TWO])
        && CAPTURE_ONE_IN == $past(SHC_IN[PIN_CAPTURE_ONE]))
        else $error("timer or capture tap wrong");
    a_tap_serial: assert property (1'b1 |=> SERIAL_CLK_IN == $past(SHC_IN[PIN_SERIAL_CLK])
        && SERIAL_DATA_IN == $past(SHC_IN[PIN_SERIAL_DATA]))
        else $error("serial tap wrong");
    a_tap_usart: assert property (1'b1 |=> USART_CLK_IN == $past(SHC_IN[PIN_USART_TX])
        && USART_DATA_IN == $past(SHC_IN[PIN_USART_RX]))
        else $error("usart tap wrong");
    // Level select must fall back to normal levels when the serial bus is off
    a_level_off: assert property (!SERIAL_I2C_EN |-> SERIAL_PIN_LEVEL == 2'b00)
        else $error("serial level select active while bus off");

    // ------------------------------------------------------------
    // Second and third port checks
    // ------------------------------------------------------------
    a_third_dir_wr: assert property (hit_wr(OFS_THIRD_DIR_CTRL)
        |=> tris_e_q == $past(WDATA[THIRD_W-1:0]))
        else $error("third direction write not taken");
    a_slave_read_drive: assert property (psp_rd |-> SCD_OE == {DATA_W{1'b1}})
        else $error("slave read did not drive the bus");
    a_slave_readback: assert property (RD_STB && ADDR == OFS_SECOND_DATA && psp_q
        |=> RDATA == $past(psp_in_q))
        else $error("slave input latch not read back");
    // Outside slave mode the input latch must hold, or stale bus noise is kept
    a_gp_no_capture: assert property (!psp_q |=> $stable(psp_in_q))
        else $error("slave latch changed in general-purpose mode");
    a_analog_wr: assert property (hit_wr(OFS_ANALOG_SEL) |=> analog_q == $past(WDATA[THIRD_W-1:0]))
        else $error("analog select write not taken");
    a_reset_third: assert property ($past(RST) |-> tris_e_q == RST_THIRD_DIR && !psp_q)
        else $error("third port reset values wrong");
    a_dir_readback: assert property (RD_STB && ADDR == OFS_SECOND_DIR
        |=> RDATA == $past(tris_d_q))
        else $error("second direction read wrong");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    c_slave_write: cover property (psp_wr ##1 RD_STB && ADDR == OFS_SECOND_DATA);
    c_slave_read: cover property (psp_rd);
    c_i2c_level: cover property (SERIAL_I2C_EN && SERIAL_LEVEL_SEL);
    c_override: cover property (PERIPH_SEL != ZERO_BYTE && tris_c_q != dir_c_eff);
    c_analog_read: cover property (RD_STB && ADDR == OFS_THIRD_DATA && analog_q != 3'h0);
endmodule : gpx_ports

// file: src/gpx_pkg.sv
// Constants for the three-port general-purpose I/O block
package gpx_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SHARED_DATA = 8'h07;
    localparam logic [7:0] OFS_SECOND_DATA = 8'h08;
    localparam logic [7:0] OFS_THIRD_DATA = 8'h09;
    localparam logic [7:0] OFS_SHARED_DIR = 8'h87;
    localparam logic [7:0] OFS_SECOND_DIR = 8'h88;
    localparam logic [7:0] OFS_THIRD_DIR_CTRL = 8'h89;
    localparam logic [7:0] OFS_ANALOG_SEL = 8'h9f;
    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int THIRD_W = 3;
    localparam int SLAVE_MODE_BIT = 4;
    localparam int STRB_READ_BIT = 0;
    localparam int STRB_WRITE_BIT = 1;
    localparam int STRB_SELECT_BIT = 2;
    // Shared-port pin roles
    localparam int PIN_TMR_OSC_OUT = 0;
    localparam int PIN_TMR_OSC_IN = 1;
    localparam int PIN_CAPTURE_TWO = 1;
    localparam int PIN_CAPTURE_ONE = 2;
    localparam int PIN_SERIAL_CLK = 3;
    localparam int PIN_SERIAL_DATA = 4;
    localparam int PIN_SERIAL_OUT = 5;
    localparam int PIN_USART_TX = 6;
    localparam int PIN_USART_RX = 7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [2:0] RST_THIRD_DIR = 3'h7;
    localparam logic [2:0] RST_ANALOG = 3'h7;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage : gpx_pkg

// file: sim/gpx_pins_model.sv
// Model of the circuits that sit on the three ports' pins
`timescale 1ns/1ps
module gpx_pins_model
(
    input wire logic clk,
    input wire logic [7:0] shc_out,
    input wire logic [7:0] shc_oe,
    input wire logic [7:0] shc_ext,
    input wire logic [7:0] scd_out,
    input wire logic [7:0] scd_oe,
    input wire logic [7:0] scd_ext,
    input wire logic [7:0] ext_en,
    input wire logic [2:0] thd_out,
    input wire logic [2:0] thd_oe,
    input wire logic [2:0] thd_ext,
    output logic [7:0] shc_in,
    output logic [7:0] scd_in,
    output logic [2:0] thd_in
);
    logic [7:0] float_q = 8'h55;
    // Released lines with ext_en low toggle so a stale level is never taken for a driven one
    always_ff @(posedge clk) float_q <= ~float_q;
    always_comb
    begin
        shc_in = (shc_oe & shc_out) | (~shc_oe & ((ext_en & shc_ext) | (~ext_en & float_q)));
        scd_in = (scd_oe & scd_out) | (~scd_oe & ((ext_en & scd_ext) | (~ext_en & float_q)));
        // Control lines are driven by the host only where the third-port pins are inputs; driven pins carry thd_out
        thd_in = (thd_oe & thd_out) | (~thd_oe & thd_ext);
    end
endmodule : gpx_pins_model

// file: sim/gpx_ports_tb.sv
// Self-checking testbench for the three-port I/O block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module gpx_ports_tb;
    import gpx_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, i2c = 1'b0, lvl = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, psel = 8'h00, poe = 8'h00, pout = 8'h00;
    logic [7:0] shc_in, shc_out, shc_oe, scd_in, scd_out, scd_oe, shc_ext = 8'h00, scd_ext = 8'h00;
    logic [7:0] ext_en = 8'hff;
    logic [2:0] thd_in, thd_out, thd_oe, thd_ext = 3'h7;
    logic [1:0] plev;
    logic [7:0] taps;
    logic slave;
    int failures = 0, total_checks = 0;
    always #2 clk = ~clk;
    gpx_ports dut_u (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR_STB(wr), .RD_STB(rd),
        .RDATA(rdata), .SHC_IN(shc_in), .SHC_OUT(shc_out), .SHC_OE(shc_oe), .PERIPH_SEL(psel),
        .PERIPH_OE(poe), .PERIPH_OUT(pout), .SERIAL_I2C_EN(i2c), .SERIAL_LEVEL_SEL(lvl),
        .SERIAL_PIN_LEVEL(plev), .TMR_CLK_IN(taps[0]), .TMR_OSC_IN(taps[1]), .CAPTURE_TWO_IN(taps[2]),
        .CAPTURE_ONE_IN(taps[3]), .SERIAL_CLK_IN(taps[4]), .SERIAL_DATA_IN(taps[5]),
        .USART_CLK_IN(taps[6]), .USART_DATA_IN(taps[7]), .SCD_IN(scd_in), .SCD_OUT(scd_out),
        .SCD_OE(scd_oe), .THD_IN(thd_in), .THD_OUT(thd_out), .THD_OE(thd_oe), .SLAVE_MODE(slave));
    gpx_pins_model pins_u (.clk(clk), .shc_out(shc_out), .shc_oe(shc_oe), .shc_ext(shc_ext),
        .scd_out(scd_out), .scd_oe(scd_oe), .scd_ext(scd_ext), .ext_en(ext_en), .thd_out(thd_out),
        .thd_oe(thd_oe), .thd_ext(thd_ext), .shc_in(shc_in), .scd_in(scd_in), .thd_in(thd_in));
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask : rd_chk
    task automatic t_reset;
        rd_chk(OFS_SHARED_DIR, 8'hff);
        rd_chk(OFS_SECOND_DIR, 8'hff);
        rd_chk(OFS_THIRD_DIR_CTRL, 8'h07);
        rd_chk(OFS_THIRD_DATA, 8'h00);
        rd_chk(8'h10, 8'h00);
        `CHK("shc_oe", 8'h00, shc_oe)
        `CHK("rdata idle", 8'h00, rdata)
        $display("t_reset done");
    endtask : t_reset
    task automatic t_taps;
        logic [7:0] p;
        for (int i = 0; i < 2; i++)
        begin
            p = i ? 8'h2a : 8'hd5;
            @(posedge clk);
            shc_ext <= p;
            repeat (2) @(posedge clk);
            #1;
            `CHK("taps", {p[7:6], p[4:3], p[2], p[1], p[1:0]}, taps)
        end
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            {i2c, lvl} <= 2'(i);
            @(posedge clk);
            #1;
            `CHK("pin level", (i[1] ? {i[0], i[0]} : 2'b00), {1'b0, plev})
        end
        $display("t_taps done");
    endtask : t_taps
    task automatic t_shared;
        shc_ext <= 8'h3c;
        wr_reg(OFS_SHARED_DATA, 8'ha5);
        wr_reg(OFS_SHARED_DIR, 8'h0f);
        `CHK("shc_oe", 8'hf0, shc_oe)
        `CHK("shc_out", 8'ha5, shc_out)
        rd_chk(OFS_SHARED_DATA, 8'hac);
        @(posedge clk);
        psel <= 8'h81;
        poe <= 8'h01;
        pout <= 8'h80;
        #1;
        `CHK("shc_oe ovr", 8'h71, shc_oe)
        `CHK("shc_out ovr", 8'ha4, shc_out)
        rd_chk(OFS_SHARED_DIR, 8'h8e);
        psel <= 8'h00;
        $display("t_shared done");
    endtask : t_shared
    task automatic t_second;
        scd_ext <= 8'h3c;
        wr_reg(OFS_SECOND_DATA, 8'h5a);
        wr_reg(OFS_SECOND_DIR, 8'hf0);
        `CHK("scd_oe", 8'h0f, scd_oe)
        rd_chk(OFS_SECOND_DATA, 8'h3a);
        $display("t_second done");
    endtask : t_second
    task automatic t_slave;
        wr_reg(OFS_ANALOG_SEL, 8'h00);
        wr_reg(OFS_THIRD_DIR_CTRL, 8'hff);
        rd_chk(OFS_THIRD_DIR_CTRL, 8'h17);
        `CHK("slave", 1'b1, slave)
        `CHK("scd_oe idle", 8'h00, scd_oe)
        @(posedge clk);
        scd_ext <= 8'hc3;
        thd_ext <= 3'b001;
        @(posedge clk);
        thd_ext <= 3'b111;
        rd_chk(OFS_SECOND_DATA, 8'hc3);
        @(posedge clk);
        thd_ext <= 3'b010;
        #1;
        `CHK("scd_oe read", 8'hff, scd_oe)
        `CHK("scd_out", 8'h5a, scd_out)
        thd_ext <= 3'b111;
        rd_chk(OFS_THIRD_DATA, 8'h07);
        wr_reg(OFS_ANALOG_SEL, 8'h05);
        rd_chk(OFS_THIRD_DATA, 8'h02);
        wr_reg(OFS_THIRD_DIR_CTRL, 8'h02);
        `CHK("thd_oe", 3'h5, thd_oe)
        `CHK("slave off", 1'b0, slave)
        `CHK("scd_oe gp", 8'h0f, scd_oe)
        wr_reg(OFS_THIRD_DIR_CTRL, 8'h07);
        $display("t_slave done");
    endtask : t_slave
    task automatic t_keep;
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("shc_oe rst", 8'h00, shc_oe)
        wr_reg(OFS_SHARED_DIR, 8'h00);
        `CHK("latch kept", 8'ha5, shc_out)
        $display("t_keep done");
    endtask : t_keep
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    initial
    begin
        #100000;
        failures++;
        conclude();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_taps();
        t_shared();
        t_second();
        t_slave();
        t_keep();
        conclude();
    end
endmodule : gpx_ports_tb
